//--- core/fcra_regs.sv
// Behaviour
// - Flash control and erase registers answer only while the select bit is 1
// - RAM emulation register answers whatever the select bit holds
// - With on-chip flash disabled, those registers read 0x00 and ignore writes
// - Writes to flash control and erase registers ignored while write enable bit is 0
// - First flash control register starts 0x80 with write enable pin high, else 0x00
// - Erase registers held 0x00 when pin low or software write enable clear
// - Flash control and erase registers are 8 bits; only byte accesses are valid, though only writes are size-checked
// - Every flash control or erase register access completes in two bus states
// - Second system control register clears on reset and hardware standby
// - Mask ROM variant: system control two ignores writes, reads undefined
// - Upper four bits of system control two ignore writes, read 0
// - Twelve erase blocks: eight 4K, one 32K, three 64K up to 0x3ffff
`timescale 1ns/1ps
`default_nettype none
`include "fcra_cfg.svh"

module fcra_regs
    import fcra_pkg::*;
#(
    parameter int         ADDR_W      = 18,
    parameter bit         MASK_ROM    = 1'b0,
    parameter fcra_byte_t UNDEF_VALUE = 8'h00
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              flash_write_enable_pin,
    input  wire logic              flash_mode_pin,
    input  wire logic              hw_standby_pin,
    input  wire logic              flash_error,
    input  wire fcra_faddr_t       probe_addr,
    output logic [7:0]             flash_ctrl_bits,
    output logic [11:0]            erase_sel,
    output logic                   reg_select,
    output logic [7:0]             ram_emu,
    output logic                   probe_armed
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       flash_write_enable;
    logic       flash_on_s;
    logic       standby_s;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end else begin
            sync1_r <= {hw_standby_pin, flash_mode_pin, flash_write_enable_pin};
            sync2_r <= sync1_r;
        end
    end

    assign flash_write_enable = sync2_r[0];
    assign flash_on_s         = sync2_r[1];
    assign standby_s          = sync2_r[2];

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    fcra_dec_if dec_if ();

    fcra_decode #(
        .ADDR_W (ADDR_W)
    ) u_decode (
        .paddr  (paddr),
        .pstrb  (pstrb),
        .pwrite (pwrite),
        .dec    (dec_if.dec)
    );

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    fcra_state_e state_r;
    fcra_state_e state_nxt;
    fcra_byte_t  sys2_r;
    fcra_byte_t  sys2_nxt;
    logic [6:0]  fc1_r;
    logic [6:0]  fc1_nxt;
    logic        err_r;
    logic        err_nxt;
    fcra_byte_t  eb_lo_r;
    fcra_byte_t  eb_lo_nxt;
    logic [3:0]  eb_hi_r;
    logic [3:0]  eb_hi_nxt;
    fcra_byte_t  ram_r;
    fcra_byte_t  ram_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic        armed_r;
    logic        armed_nxt;

    // ----------------------------------------
    // Access qualification
    // ----------------------------------------
    logic       sel_bit;
    logic       software_write_enable;
    logic       flash_vis;
    logic       flash_open;
    logic       unmapped;
    logic       bad_size;
    logic       setup;
    logic       wr_fire;
    logic       wr_flash;
    logic       eb_hold;
    fcra_byte_t fc1_rd;
    fcra_byte_t fc2_rd;
    fcra_byte_t sys2_rd;
    fcra_byte_t eb_hi_rd;
    fcra_byte_t rd_byte;
    fcra_byte_t wr_byte;
    logic [3:0] probe_blk;
    logic [11:0] eb_all;

    assign sel_bit = sys2_r[`FCRA_SYS2_SEL_BIT];
    assign software_write_enable = fc1_r[`FCRA_FC1_SW_WE_BIT];

    // Flash registers exist at their addresses only when selected
    assign flash_vis  = dec_if.hit_flash & sel_bit;
    // Disabled flash: still mapped, but reads zero and writes drop
    assign flash_open = flash_vis & flash_on_s;

    // RAM emulation never looks at the select bit
    assign unmapped = ~(dec_if.hit_ram | dec_if.hit_sys2 | flash_vis);

    // A wide write to a flash register is refused outright
    assign bad_size = flash_vis & ~dec_if.byte_ok;

    assign setup   = psel & ~penable & (state_r == FCRA_IDLE);
    assign wr_fire = psel & penable & pwrite & pready_r & ~pslverr_r;
    assign wr_byte = pwdata[7:0];

    // Writes into the flash group need the enable bit and an enabled flash
    assign wr_flash = wr_fire & flash_open & flash_write_enable;

    // Erase selection only survives while both enables stand
    assign eb_hold = ~flash_write_enable | ~software_write_enable;

    // ----------------------------------------
    // Read view
    // ----------------------------------------
    // Enable bit mirrors the pin, so a high pin shows 0x80 out of reset
    assign fc1_rd   = {flash_write_enable, fc1_r};
    assign fc2_rd   = {err_r, 7'h00};
    assign eb_hi_rd = {4'h0, eb_hi_r};
    assign sys2_rd  = MASK_ROM ? UNDEF_VALUE : sys2_r;

    always_comb begin
        rd_byte = `FCRA_RST_BYTE;
        if (dec_if.hit_ram) begin
            rd_byte = ram_r;
        end else if (dec_if.hit_sys2) begin
            rd_byte = sys2_rd;
        end else if (!flash_open) begin
            rd_byte = `FCRA_RST_BYTE;
        end else if (dec_if.hit_fc1) begin
            rd_byte = fc1_rd;
        end else if (dec_if.hit_fc2) begin
            rd_byte = fc2_rd;
        end else if (dec_if.hit_eb_lo) begin
            rd_byte = eb_lo_r;
        end else begin
            rd_byte = eb_hi_rd;
        end
    end

    // ----------------------------------------
    // Bus state machine
    // ----------------------------------------
    // Setup samples the request, the next state answers: two states in all
    always_comb begin
        state_nxt   = state_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = pslverr_r;
        prdata_nxt  = prdata_r;
        case (state_r)
            FCRA_IDLE: begin
                if (setup) begin
                    state_nxt   = FCRA_RESP;
                    pready_nxt  = 1'b1;
                    pslverr_nxt = unmapped | bad_size;
                    prdata_nxt  = 32'h0;
                    if (!pwrite && !unmapped) begin
                        prdata_nxt = {24'h0, rd_byte};
                    end
                end
            end
            FCRA_RESP: begin
                state_nxt   = FCRA_IDLE;
                pslverr_nxt = 1'b0;
            end
            default: begin
                state_nxt = FCRA_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // System control two
    // ----------------------------------------
    always_comb begin
        sys2_nxt = sys2_r;
        if (standby_s) begin
            sys2_nxt = `FCRA_RST_BYTE;
        end else if (wr_fire && dec_if.hit_sys2 && !MASK_ROM) begin
            // Only the select bit takes a write; bits 7..4 stay zero
            sys2_nxt = wr_byte & `FCRA_SYS2_WR_MASK;
        end
    end

    // ----------------------------------------
    // Flash control one and two
    // ----------------------------------------
    always_comb begin
        fc1_nxt = fc1_r;
        if (!flash_write_enable) begin
            fc1_nxt = 7'h00;
        end else if (wr_flash && dec_if.hit_fc1) begin
            fc1_nxt = wr_byte[6:0];
        end
    end

    // Error flag only sets from the flash; a write cannot clear it
    assign err_nxt = err_r | flash_error;

    // ----------------------------------------
    // Erase block selection
    // ----------------------------------------
    always_comb begin
        eb_lo_nxt = eb_lo_r;
        eb_hi_nxt = eb_hi_r;
        if (eb_hold) begin
            eb_lo_nxt = `FCRA_RST_BYTE;
            eb_hi_nxt = 4'h0;
        end else if (wr_flash && dec_if.hit_eb_lo) begin
            eb_lo_nxt = wr_byte;
        end else if (wr_flash && dec_if.hit_eb_hi) begin
            eb_hi_nxt = wr_byte[`FCRA_EB_HI_BITS-1:0];
        end
    end

    assign eb_all = {eb_hi_r, eb_lo_r};

    // Flags whether a flash address falls in a block marked for erase
    assign probe_blk = fcra_block_of(probe_addr);
    assign armed_nxt = eb_all[probe_blk];

    // ----------------------------------------
    // RAM emulation
    // ----------------------------------------
    always_comb begin
        ram_nxt = ram_r;
        if (wr_fire && dec_if.hit_ram) begin
            ram_nxt = wr_byte;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r   <= FCRA_IDLE;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            state_r   <= state_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sys2_r <= `FCRA_RST_BYTE;
            fc1_r  <= 7'h00;
            err_r  <= 1'b0;
        end else begin
            sys2_r <= sys2_nxt;
            fc1_r  <= fc1_nxt;
            err_r  <= err_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            eb_lo_r <= `FCRA_RST_BYTE;
            eb_hi_r <= 4'h0;
            ram_r   <= `FCRA_RST_BYTE;
            armed_r <= 1'b0;
        end else begin
            eb_lo_r <= eb_lo_nxt;
            eb_hi_r <= eb_hi_nxt;
            ram_r   <= ram_nxt;
            armed_r <= armed_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic [7:0] ctrl_out_r;
    logic       sel_out_r;

    // Output copies lag the registers by one cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_out_r <= `FCRA_RST_BYTE;
            sel_out_r  <= 1'b0;
        end else begin
            ctrl_out_r <= fc1_rd;
            sel_out_r  <= sel_bit;
        end
    end

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign flash_ctrl_bits = ctrl_out_r;
    assign erase_sel       = eb_all;
    assign reg_select      = sel_out_r;
    assign ram_emu         = ram_r;
    assign probe_armed     = armed_r;

endmodule : fcra_regs

`default_nettype wire

//--- core/fcra_cfg.svh
`ifndef FCRA_CFG_SVH
`define FCRA_CFG_SVH

// ----------------------------------------
// Register indices, byte address = 4 * index
// ----------------------------------------
`define FCRA_IDX_RAM_EMU     16'hfedb
`define FCRA_IDX_SYS_CTRL2   16'hff42
`define FCRA_IDX_FLASH_CTL1  16'hffc8
`define FCRA_IDX_FLASH_CTL2  16'hffc9
`define FCRA_IDX_ERASE_LO    16'hffca
`define FCRA_IDX_ERASE_HI    16'hffcb

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FCRA_SYS2_SEL_BIT    3
`define FCRA_FC1_PIN_WE_BIT  7
`define FCRA_FC1_SW_WE_BIT   6
`define FCRA_FC2_ERR_BIT     7
`define FCRA_EB_HI_BITS      4

// ----------------------------------------
// Reset and fixed read values
// ----------------------------------------
`define FCRA_RST_BYTE        8'h00
`define FCRA_SYS2_WR_MASK    8'h08
`define FCRA_BYTE_STRB       4'h1

// ----------------------------------------
// Timing: access takes setup plus one state
// ----------------------------------------
`define FCRA_ACCESS_STATES   2

`endif

//--- core/fcra_pkg.sv
package fcra_pkg;

    `include "fcra_cfg.svh"

    typedef logic [7:0]  fcra_byte_t;
    typedef logic [17:0] fcra_faddr_t;

    // Gray sequence: idle -> respond
    typedef enum logic [1:0] {
        FCRA_IDLE = 2'b00,
        FCRA_RESP = 2'b01
    } fcra_state_e;

    function automatic logic [17:0] fcra_byte_addr(input logic [15:0] idx);
        fcra_byte_addr = {idx, 2'b00};
    endfunction : fcra_byte_addr

    // Erase block holding a flash byte address
    function automatic logic [3:0] fcra_block_of(input fcra_faddr_t a);
        if (a[17:16] != 2'b00) begin
            fcra_block_of = {2'b10, a[17:16]} + 4'h0;
        end else if (a[15]) begin
            fcra_block_of = 4'h8;
        end else begin
            fcra_block_of = {1'b0, a[14:12]};
        end
    endfunction : fcra_block_of

endpackage : fcra_pkg

//--- core/fcra_dec_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fcra_dec_if;
    logic hit_ram;
    logic hit_sys2;
    logic hit_fc1;
    logic hit_fc2;
    logic hit_eb_lo;
    logic hit_eb_hi;
    logic hit_flash;
    logic byte_ok;

    modport dec (output hit_ram, hit_sys2, hit_fc1, hit_fc2,
                 output hit_eb_lo, hit_eb_hi, hit_flash, byte_ok);
    modport use_side (input hit_ram, hit_sys2, hit_fc1, hit_fc2,
                      input hit_eb_lo, hit_eb_hi, hit_flash, byte_ok);
endinterface : fcra_dec_if

`default_nettype wire

//--- core/fcra_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcra_cfg.svh"

module fcra_decode
    import fcra_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [3:0]        pstrb,
    input  wire logic              pwrite,
    fcra_dec_if.dec                dec
);
    // ----------------------------------------
    // Address match
    // ----------------------------------------
    assign dec.hit_ram   = (paddr == fcra_byte_addr(`FCRA_IDX_RAM_EMU));
    assign dec.hit_sys2  = (paddr == fcra_byte_addr(`FCRA_IDX_SYS_CTRL2));
    assign dec.hit_fc1   = (paddr == fcra_byte_addr(`FCRA_IDX_FLASH_CTL1));
    assign dec.hit_fc2   = (paddr == fcra_byte_addr(`FCRA_IDX_FLASH_CTL2));
    assign dec.hit_eb_lo = (paddr == fcra_byte_addr(`FCRA_IDX_ERASE_LO));
    assign dec.hit_eb_hi = (paddr == fcra_byte_addr(`FCRA_IDX_ERASE_HI));
    assign dec.hit_flash = dec.hit_fc1 | dec.hit_fc2 | dec.hit_eb_lo | dec.hit_eb_hi;

    // Reads carry no size on the bus, so only writes are checked
    assign dec.byte_ok   = ~pwrite | (pstrb == `FCRA_BYTE_STRB);
endmodule : fcra_decode

`default_nettype wire

//--- verif/fcra_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none

module fcra_regs_sva
    import fcra_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    input wire logic              core_clk,
    input wire logic              rst_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              flash_write_enable_pin,
    input wire logic              flash_mode_pin,
    input wire logic              hw_standby_pin,
    input wire logic [7:0]        flash_ctrl_bits,
    input wire logic [11:0]       erase_sel,
    input wire logic              reg_select,
    input wire logic              probe_armed
);
    // --------------------
    // Assertions
    // --------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Flash block occupies 0x3ff20..0x3ff2c
    wire logic fl_hit  = (paddr[ADDR_W-1:4] == 14'h3ff2) && (paddr[1:0] == 2'b00);
    wire logic rd_done = pready && !pwrite;

    a_two_states: assert property (psel && !penable |=> pready && penable)
        else $error("access did not finish in two states");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_byte_lanes: assert property (rd_done |-> prdata[31:8] == 24'h000000)
        else $error("upper read lanes not zero");
    a_unselected_err: assert property (pready && fl_hit && !reg_select |-> pslverr)
        else $error("unselected flash register answered");
    a_ram_no_err: assert property (pready && paddr == 18'h3fb6c |-> !pslverr)
        else $error("ram emulation access refused");
    a_sys_upper: assert property (rd_done && paddr == 18'h3fd08 |-> prdata[7:4] == 4'h0)
        else $error("system control upper bits not zero");
    a_standby_clear: assert property (hw_standby_pin [*6] |-> !reg_select)
        else $error("standby did not clear select");
    a_enable_pin_low: assert property (!flash_write_enable_pin [*5] |-> !flash_ctrl_bits[7])
        else $error("write enable bit set with pin low");
    a_erase_held: assert property (!flash_ctrl_bits[6] [*3] |-> erase_sel == 12'h000)
        else $error("erase select not held clear");
    a_disabled_zero: assert property (!flash_mode_pin [*6] ##0 rd_done && fl_hit |-> prdata[7:0] == 8'h00)
        else $error("disabled flash register read not zero");

    c_err: cover property (pready && pslverr);
    c_probe: cover property (probe_armed);
    c_standby: cover property (hw_standby_pin && reg_select);

endmodule : fcra_regs_sva

bind fcra_regs fcra_regs_sva #(.ADDR_W(ADDR_W)) u_sva (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_write_enable_pin(flash_write_enable_pin),
    .flash_mode_pin(flash_mode_pin), .hw_standby_pin(hw_standby_pin),
    .flash_ctrl_bits(flash_ctrl_bits), .erase_sel(erase_sel), .reg_select(reg_select),
    .probe_armed(probe_armed)
);

`default_nettype wire

//--- verif/test_flash_control_register_access.sv
`timescale 1ns/1ps
`default_nettype none

module test_flash_control_register_access
    import fcra_pkg::*;
;
    localparam logic [17:0] A_RAM = 18'h3fb6c;
    localparam logic [17:0] A_SYS = 18'h3fd08;
    localparam logic [17:0] A_FC1 = 18'h3ff20;
    localparam logic [17:0] A_FC2 = 18'h3ff24;
    localparam logic [17:0] A_EBL = 18'h3ff28;
    localparam logic [17:0] A_EBH = 18'h3ff2c;
    localparam fcra_faddr_t BLK [12] = '{18'h00000, 18'h01000, 18'h02000, 18'h03000, 18'h04000,
        18'h05000, 18'h06000, 18'h07000, 18'h08000, 18'h10000, 18'h20000, 18'h30000};

    logic        core_clk       = 1'b0;
    logic        rst_n          = 1'b0;
    logic        psel           = 1'b0;
    logic        penable        = 1'b0;
    logic        pwrite         = 1'b0;
    logic [17:0] paddr          = 18'h00000;
    logic [31:0] pwdata         = 32'h00000000;
    logic [3:0]  pstrb          = 4'h1;
    logic        flash_write_enable_pin = 1'b0;
    logic        flash_mode_pin = 1'b1;
    logic        hw_standby_pin = 1'b0;
    logic        flash_error    = 1'b0;
    fcra_faddr_t probe_addr     = 18'h00000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  flash_ctrl_bits;
    logic [11:0] erase_sel;
    logic        reg_select;
    logic [7:0]  ram_emu;
    logic        probe_armed;
    logic [31:0] rom_prdata;
    logic        rom_reg_select;
    // Arbitrary stand-in for the undefined read of a mask ROM build
    localparam fcra_byte_t ROM_UNDEF = 8'h05;
    int          miscompares    = 0;
    int          compares       = 0;

    always #2.5 core_clk = ~core_clk;

    fcra_regs u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_write_enable_pin(flash_write_enable_pin), .flash_mode_pin(flash_mode_pin),
        .hw_standby_pin(hw_standby_pin), .flash_error(flash_error), .probe_addr(probe_addr),
        .flash_ctrl_bits(flash_ctrl_bits), .erase_sel(erase_sel), .reg_select(reg_select),
        .ram_emu(ram_emu), .probe_armed(probe_armed)
    );

    // Mask ROM build on the same bus: its system control register must stay frozen
    fcra_regs #(
        .MASK_ROM    (1'b1),
        .UNDEF_VALUE (ROM_UNDEF)
    ) u_dut_rom (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(rom_prdata), .pready(),
        .pslverr(), .flash_write_enable_pin(flash_write_enable_pin), .flash_mode_pin(flash_mode_pin),
        .hw_standby_pin(hw_standby_pin), .flash_error(flash_error), .probe_addr(probe_addr),
        .flash_ctrl_bits(), .erase_sel(), .reg_select(rom_reg_select),
        .ram_emu(), .probe_armed()
    );

    // --------------------
    // Tasks
    // --------------------
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string nm, input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // Read data and response are taken at the edge that sees pready
    task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d,
                        input logic [3:0] s, input logic [7:0] ed, input logic ee);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        pstrb   <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            miscompares++;
            complete_run();
        end
        check("pslverr", {11'h000, ee}, {11'h000, pslverr});
        if (!w) begin
            check("prdata", {4'h0, ed}, {4'h0, prdata[7:0]});
        end
    endtask : xfer

    task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic ee);
        xfer(1'b1, a, d, 4'h1, 8'h00, ee);
    endtask : wr

    task automatic rd(input logic [17:0] a, input logic [7:0] ed, input logic ee);
        xfer(1'b0, a, 8'h00, 4'h1, ed, ee);
    endtask : rd

    task automatic probe(input fcra_faddr_t a, input logic e);
        probe_addr <= a;
        repeat (2) @(posedge core_clk);
        check("probe_armed", {11'h000, e}, {11'h000, probe_armed});
    endtask : probe

    // --------------------
    // Sequence
    // --------------------
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(A_FC1, 8'h00, 1'b1);
        wr(A_EBL, 8'hff, 1'b1);
        wr(A_RAM, 8'h5a, 1'b0);
        rd(A_RAM, 8'h5a, 1'b0);
        check("ram_emu", 12'h05a, {4'h0, ram_emu});
        rd(A_SYS, 8'h00, 1'b0);
        wr(A_SYS, 8'hff, 1'b0);
        rd(A_SYS, 8'h08, 1'b0);
        check("reg_select", 12'h001, {11'h000, reg_select});
        check("rom reg_select", 12'h000, {11'h000, rom_reg_select});
        check("rom prdata", {4'h0, ROM_UNDEF}, {4'h0, rom_prdata[7:0]});
        rd(A_FC1, 8'h00, 1'b0);
        rd(A_EBL, 8'h00, 1'b0);
        wr(A_FC1, 8'h40, 1'b0);
        rd(A_FC1, 8'h00, 1'b0);
        flash_write_enable_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(A_FC1, 8'h80, 1'b0);
        wr(A_FC1, 8'h40, 1'b0);
        rd(A_FC1, 8'hc0, 1'b0);
        check("flash_ctrl_bits", 12'h0c0, {4'h0, flash_ctrl_bits});
        wr(A_EBH, 8'hff, 1'b0);
        rd(A_EBH, 8'h0f, 1'b0);
        xfer(1'b1, A_EBL, 8'h33, 4'hf, 8'h00, 1'b1);
        rd(A_EBL, 8'h00, 1'b0);
        // One select bit per block; probe both ends and the next block's start
        for (int b = 0; b < 12; b++) begin
            wr(A_EBL, (b < 8) ? (8'h01 << b) : 8'h00, 1'b0);
            wr(A_EBH, (b < 8) ? 8'h00 : (8'h01 << (b - 8)), 1'b0);
            probe(BLK[b], 1'b1);
            check("erase_sel", 12'h001 << b, erase_sel);
            probe((b == 11) ? 18'h3ffff : BLK[b + 1] - 18'h00001, 1'b1);
            if (b < 11) begin
                probe(BLK[b + 1], 1'b0);
            end
        end
        flash_error <= 1'b1;
        @(posedge core_clk);
        flash_error <= 1'b0;
        rd(A_FC2, 8'h80, 1'b0);
        wr(A_FC1, 8'h00, 1'b0);
        rd(A_EBH, 8'h00, 1'b0);
        flash_write_enable_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(A_FC1, 8'h00, 1'b0);
        flash_write_enable_pin <= 1'b1;
        flash_mode_pin         <= 1'b0;
        repeat (8) @(posedge core_clk);
        rd(A_FC1, 8'h00, 1'b0);
        wr(A_FC1, 8'h40, 1'b0);
        flash_mode_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(A_FC1, 8'h80, 1'b0);
        hw_standby_pin <= 1'b1;
        repeat (8) @(posedge core_clk);
        hw_standby_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(A_SYS, 8'h00, 1'b0);
        rd(A_FC1, 8'h00, 1'b1);
        complete_run();
    end

endmodule : test_flash_control_register_access

`default_nettype wire
